// ==== dv/interrupt_source_control_assertions.sv ====
// Port-level checks of the source control block
module interrupt_source_control_assertions
(
    // Clock, reset and inputs
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic        i_rd,
    input wire logic        i_watchdog_view,
    input wire logic [6:0]  i_service_ack,
    // Outputs
    input wire logic [15:0] o_rdata,
    input wire logic        o_ack_output_first_n,
    input wire logic        o_ack_output_first_oe,
    input wire logic        o_ack_output_second_n,
    input wire logic        o_ack_output_second_oe,
    input wire logic [15:0] o_request_status,
    input wire logic [15:0] o_mask_mirror,
    input wire logic        o_pend_valid,
    input wire logic [7:0]  o_pend_type,
    input wire logic [2:0]  o_pend_prio,
    input wire logic [1:0]  o_cascade_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_first_oe: assert property (o_ack_output_first_oe == o_cascade_enable[0])
        else $error("first ack enable differs from cascade bit");
    a_second_oe: assert property (o_ack_output_second_oe == o_cascade_enable[1])
        else $error("second ack enable differs from cascade bit");
    a_first_ack: assert property (i_service_ack[0] && o_cascade_enable[0] |=> !o_ack_output_first_n)
        else $error("first ack pulse missing");
    a_second_cause: assert property (!o_ack_output_second_n |-> $past(i_service_ack[1]))
        else $error("second ack pulse without service");
    a_line_reserved: assert property ($past(i_rd) && $past(i_addr) == 8'h38 |-> o_rdata[15:7] == 9'h000)
        else $error("line control reserved bits set");
    a_serial_bit4: assert property ($past(i_rd) && $past(i_addr) == 8'h44 && !$past(i_watchdog_view) |-> o_rdata[4])
        else $error("serial control bit 4 not one");
    a_pend_open: assert property (o_pend_valid |-> |(o_request_status & ~o_mask_mirror))
        else $error("pending from blocked source");
    a_idle_prio: assert property (!o_pend_valid |-> o_pend_prio == 3'h7)
        else $error("idle priority not lowest");
    a_type_legal: assert property (o_pend_valid |-> o_pend_type inside {[8'h0c:8'h11], 8'h14})
        else $error("pending type out of range");
    a_mirror_map: assert property (o_mask_mirror[15:11] == 5'h00 && o_mask_mirror[3:0] == 4'h0)
        else $error("mask mirror reserved bits set");
endmodule // interrupt_source_control_assertions

bind interrupt_source_control interrupt_source_control_assertions u_interrupt_source_control_assertions (.*);

// ==== dv/request_source_model.sv ====
// Behavioural external requesters for the five request lines
module request_source_model
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    // Raise command and service acknowledge
    input  wire logic [4:0] i_raise,
    input  wire logic [6:0] i_service_ack,
    // Request lines
    output logic      [4:0] o_line
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_line <= 5'h00;
        else
            o_line <= (o_line | i_raise) & ~i_service_ack[4:0];
    end
endmodule // request_source_model

// ==== dv/tb_interrupt_source_control.sv ====
// Self-checking bench for the source control block
module tb_interrupt_source_control;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

    // ==========================================
    // Signals
    logic        i_core_clk = 1'h0;
    logic        i_rst_n = 1'h0;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'h0, i_rd = 1'h0, i_watchdog_view = 1'h0;
    logic        i_serial_req = 1'h0, i_watchdog_req = 1'h0;
    logic [6:0]  i_service_ack = 7'h00;
    logic [4:0]  raise = 5'h00;
    wire  [4:0]  i_ext_request_line;
    wire  [15:0] o_rdata, o_request_status, o_mask_mirror;
    wire         o_ack_output_first_n, o_ack_output_first_oe, o_pend_valid;
    wire         o_ack_output_second_n, o_ack_output_second_oe;
    wire  [7:0]  o_pend_type;
    wire  [2:0]  o_pend_prio;
    wire  [1:0]  o_special_nested_enable, o_cascade_enable;
    int          n_mismatch = 0, check_count = 0, cycles = 0;

    interrupt_source_control u_interrupt_source_control (.*);
    request_source_model u_request_source_model (.i_core_clk, .i_rst_n, .i_raise(raise), .i_service_ack,
                                                 .o_line(i_ext_request_line));

    always #12.5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ==========================================
    // Bus and helper tasks
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        #1 `CHK("rdata", e, o_rdata)
        @(posedge i_core_clk);
    endtask

    task automatic wait_pend(input logic v);
        int k;
        for (k = 0; k < 12 && o_pend_valid !== v; k++)
            @(posedge i_core_clk) #1;
    endtask

    task automatic ack(input int s);
        @(posedge i_core_clk);
        i_service_ack[s] <= 1'h1;
        @(posedge i_core_clk);
        i_service_ack <= 7'h00;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        int i;
        for (i = 0; i < 5; i++)
            rd(8'h38 + 8'(2 * i), 16'h000f);
        rd(8'h44, 16'h001f);
        i_watchdog_view <= 1'h1;
        rd(8'h44, 16'h000f);
        i_watchdog_view <= 1'h0;
        rd(8'h28, 16'h07f0);
        rd(8'h50, 16'h0000);
        $display("t_reset done");
    endtask

    task automatic t_fields;
        wr(8'h38, 16'hfff7);
        rd(8'h38, 16'h0077);
        `CHK("nested", 2'h1, o_special_nested_enable)
        `CHK("cascade", 2'h1, o_cascade_enable)
        rd(8'h28, 16'h07e0);
        wr(8'h28, 16'h07d0);
        rd(8'h3a, 16'h0007);
        rd(8'h38, 16'h007f);
        wr(8'h28, 16'h07f0);
        wr(8'h3c, 16'hffff);
        rd(8'h3c, 16'h001f);
        wr(8'h44, 16'hfff0);
        rd(8'h44, 16'h0010);
        i_watchdog_view <= 1'h1;
        wr(8'h44, 16'hffff);
        rd(8'h44, 16'h000f);
        i_watchdog_view <= 1'h0;
        wr(8'h38, 16'h000f);
        wr(8'h3c, 16'h000f);
        wr(8'h44, 16'h001f);
        $display("t_fields done");
    endtask

    task automatic t_lines;
        int i;
        logic [15:0] cfg;
        for (i = 0; i < 5; i++)
        begin
            cfg = {11'h000, 1'(i % 2), 1'h1, 3'(i)};
            wr(8'h38 + 8'(2 * i), cfg);
            raise[i] <= 1'h1;
            @(posedge i_core_clk);
            raise <= 5'h00;
            repeat (8) @(posedge i_core_clk);
            #1 `CHK("status", 1'h1, o_request_status[4 + i])
            `CHK("blocked", 1'h0, o_pend_valid)
            rd(8'h2e, 16'h0010 << i);
            wr(8'h38 + 8'(2 * i), cfg & 16'hfff7);
            wait_pend(1'h1);
            `CHK("type", 8'h0c + 8'(i), o_pend_type)
            `CHK("prio", 3'(i), o_pend_prio)
            ack(i);
            wait_pend(1'h0);
            `CHK("cleared", 1'h0, o_request_status[4 + i])
            wr(8'h38 + 8'(2 * i), 16'h000f);
        end
        $display("t_lines done");
    endtask

    task automatic t_casc;
        wr(8'h38, 16'h006f);
        wr(8'h3a, 16'h006f);
        #1 `CHK("second oe", 1'h1, o_ack_output_second_oe)
        `CHK("first oe on", 1'h1, o_ack_output_first_oe)
        `CHK("nested both", 2'h3, o_special_nested_enable)
        ack(0);
        #1 `CHK("first ack", 1'h0, o_ack_output_first_n)
        ack(1);
        #1 `CHK("second ack", 1'h0, o_ack_output_second_n)
        wr(8'h38, 16'h000f);
        wr(8'h3a, 16'h000f);
        #1 `CHK("first oe", 1'h0, o_ack_output_first_oe)
        $display("t_casc done");
    endtask

    task automatic t_internal;
        wr(8'h44, 16'h0003);
        i_serial_req <= 1'h1;
        wait_pend(1'h1);
        `CHK("serial type", 8'h14, o_pend_type)
        `CHK("serial status", 1'h1, o_request_status[10])
        @(posedge i_core_clk);
        i_serial_req <= 1'h0;
        wr(8'h44, 16'h001f);
        wait_pend(1'h0);
        @(posedge i_core_clk);
        i_watchdog_view <= 1'h1;
        wr(8'h44, 16'h0001);
        i_watchdog_req <= 1'h1;
        wait_pend(1'h1);
        `CHK("watchdog prio", 3'h1, o_pend_prio)
        @(posedge i_core_clk);
        i_watchdog_req <= 1'h0;
        wr(8'h44, 16'h000f);
        i_watchdog_view <= 1'h0;
        $display("t_internal done");
    endtask

    // ==========================================
    // Verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'h1;
        t_reset();
        t_fields();
        t_lines();
        t_casc();
        t_internal();
        wrap_up();
    end
endmodule // tb_interrupt_source_control

// ==== rtl/interrupt_source_control.v ====
// Per-source mask and priority control, trigger control for the five request lines, with pending logic and cascade acknowledge pins
//
// Design decision made here: the address-and-strobe port.
`include "interrupt_source_control_map.vh"

module interrupt_source_control
(
    // Clock and reset
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    // Register port
    input  wire [7:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire        i_watchdog_view,
    output wire [15:0] o_rdata,
    // Request lines from pins
    input  wire [4:0]  i_ext_request_line,
    // Internal sources
    input  wire        i_serial_req,
    input  wire        i_watchdog_req,
    // Service acknowledge from controller, bit per source
    input  wire [6:0]  i_service_ack,
    // Cascade acknowledge pins
    output wire        o_ack_output_first_n,
    output wire        o_ack_output_first_oe,
    output wire        o_ack_output_second_n,
    output wire        o_ack_output_second_oe,
    // Controller view
    output wire [15:0] o_request_status,
    output wire [15:0] o_mask_mirror,
    output wire        o_pend_valid,
    output wire [7:0]  o_pend_type,
    output wire [2:0]  o_pend_prio,
    output wire [1:0]  o_special_nested_enable,
    output wire [1:0]  o_cascade_enable
);

    localparam NSRC       = 7;
    localparam SRC_SERIAL = 5;
    localparam SRC_WDOG   = 6;

    // =============================================================
    // Status bit positions and serial storage
    localparam [3:0]  POS_LINE0    = `ISC_POS_LINE0;
    localparam [3:0]  POS_SERIAL   = `ISC_POS_SERIAL;
    localparam [3:0]  POS_WATCHDOG = `ISC_POS_WATCHDOG;
    // Fixed bit 4 is not stored, the read path adds it
    localparam [15:0] SERIAL_STORE = `ISC_RST_SERIAL & ~`ISC_SERIAL_FIXED;

    // =============================================================
    // State
    reg  [6:0]  ctl_reg [0:NSRC-1];
    reg  [4:0]  sync1_reg;
    reg  [4:0]  sync2_reg;
    reg  [4:0]  prev_reg;
    reg  [4:0]  edge_pend_reg;
    reg  [15:0] rdata_reg;
    reg  [15:0] req_status_reg;
    reg  [15:0] mask_mirror_reg;
    reg         pend_valid_reg;
    reg  [7:0]  pend_type_reg;
    reg  [2:0]  pend_prio_reg;
    reg  [1:0]  ack_out_reg;

    reg  [15:0] rdata_next;
    reg  [15:0] req_status_next;
    reg  [15:0] mask_mirror_next;
    reg         pend_valid_next;
    reg  [7:0]  pend_type_next;
    reg  [2:0]  pend_prio_next;
    reg         sel_hit;
    reg  [2:0]  sel_idx;
    reg  [6:0]  sel_wmask;
    reg  [6:0]  src_req;
    reg  [6:0]  src_live;
    reg  [4:0]  edge_pend_next;

    wire [1:0]  cascade_on;
    wire [1:0]  nested_on;

    integer     k_rst;
    integer     k_edge;
    integer     k_req;
    integer     k_sts;

    function [7:0] src_type;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    src_type = `ISC_TYPE_LINE0;
                3'h1:    src_type = `ISC_TYPE_LINE1;
                3'h2:    src_type = `ISC_TYPE_LINE2;
                3'h3:    src_type = `ISC_TYPE_LINE3;
                3'h4:    src_type = `ISC_TYPE_LINE4;
                3'h5:    src_type = `ISC_TYPE_SERIAL;
                default: src_type = `ISC_TYPE_WATCHDOG;
            endcase
        end
    endfunction

    function [3:0] status_pos;
        input [2:0] idx;
        begin
            if (idx == 3'd5)
                status_pos = POS_SERIAL;
            else if (idx == 3'd6)
                status_pos = POS_WATCHDOG;
            else
                status_pos = POS_LINE0 + {1'b0, idx};
        end
    endfunction

    // =============================================================
    // Option bits of lines 0 and 1
    // cascade enable
    assign cascade_on = {ctl_reg[1][`ISC_CASCADE_BIT], ctl_reg[0][`ISC_CASCADE_BIT]};
    assign nested_on  = {ctl_reg[1][`ISC_NESTED_BIT], ctl_reg[0][`ISC_NESTED_BIT]};

    // =============================================================
    // Address decode
    always @*
    begin
        sel_hit   = 1'b1;
        sel_idx   = 3'd0;
        sel_wmask = `ISC_WMASK_LINE01;
        if (i_addr == `ISC_OFF_LINE0_CTL)
        begin
            sel_idx = 3'd0;
        end
        else if (i_addr == `ISC_OFF_LINE1_CTL)
        begin
            sel_idx = 3'd1;
        end
        else if (i_addr == `ISC_OFF_LINE2_CTL)
        begin
            sel_idx   = 3'd2;
            sel_wmask = `ISC_WMASK_LINE234;
        end
        else if (i_addr == `ISC_OFF_LINE3_CTL)
        begin
            sel_idx   = 3'd3;
            sel_wmask = `ISC_WMASK_LINE234;
        end
        else if (i_addr == `ISC_OFF_LINE4_CTL)
        begin
            sel_idx   = 3'd4;
            sel_wmask = `ISC_WMASK_LINE234;
        end
        else if (i_addr == `ISC_OFF_SOURCE_CTL)
        begin
            // Shared offset, view input picks the watchdog copy
            sel_idx   = i_watchdog_view ? 3'd6 : 3'd5;
            sel_wmask = `ISC_WMASK_INTERNAL;
        end
        else
        begin
            sel_hit = 1'b0;
        end
    end

    // =============================================================
    // Control registers
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (k_rst = 0; k_rst < 5; k_rst = k_rst + 1)
            begin
                ctl_reg[k_rst] <= `ISC_RST_LINE;
            end
            ctl_reg[SRC_SERIAL] <= SERIAL_STORE[6:0];
            ctl_reg[SRC_WDOG]   <= `ISC_RST_WATCHDOG;
        end
        else if (i_wr && sel_hit)
        begin
            ctl_reg[sel_idx] <= (ctl_reg[sel_idx] & ~sel_wmask) | (i_wdata[6:0] & sel_wmask);
        end
        else if (i_wr && (i_addr == `ISC_OFF_MASK_MIRROR))
        begin
            // mirror write updates each block bit
            for (k_rst = 0; k_rst < NSRC; k_rst = k_rst + 1)
            begin
                ctl_reg[k_rst][`ISC_BLOCK_BIT] <= i_wdata[status_pos(k_rst[2:0])];
            end
        end
    end

    // =============================================================
    // Pin synchroniser and edge detect
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg  <= 5'h00;
        end
        else
        begin
            sync1_reg <= i_ext_request_line;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    always @*
    begin
        for (k_edge = 0; k_edge < 5; k_edge = k_edge + 1)
        begin
            // Latches while blocked too, block bit gates dispatch only
            // set on rising edge wins over acknowledge
            if (sync2_reg[k_edge] && !prev_reg[k_edge])
                edge_pend_next[k_edge] = 1'b1;
            else if (i_service_ack[k_edge])
                edge_pend_next[k_edge] = 1'b0;
            else
                edge_pend_next[k_edge] = edge_pend_reg[k_edge];
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            edge_pend_reg <= 5'h00;
        else
            edge_pend_reg <= edge_pend_next;
    end

    // =============================================================
    // Request and live request per source
    always @*
    begin
        for (k_req = 0; k_req < 5; k_req = k_req + 1)
        begin
            // lines 2, 3 and 4 level or edge
            // lines 0 and 1 level or edge
            if (ctl_reg[k_req][`ISC_LEVEL_BIT])
                src_req[k_req] = sync2_reg[k_req];
            else
                src_req[k_req] = edge_pend_reg[k_req];
        end
        // pins used as acknowledge outputs request nothing
        if (cascade_on[0])
            src_req[2] = 1'b0;
        if (cascade_on[1])
            src_req[3] = 1'b0;
        // Internal sources are same-clock levels
        src_req[SRC_SERIAL] = i_serial_req;
        src_req[SRC_WDOG]   = i_watchdog_req;
        for (k_req = 0; k_req < NSRC; k_req = k_req + 1)
        begin
            src_live[k_req] = src_req[k_req] & ~ctl_reg[k_req][`ISC_BLOCK_BIT];
        end
    end

    // =============================================================
    // Status, mirror and highest pending source
    always @*
    begin
        req_status_next  = 16'h0000;
        mask_mirror_next = 16'h0000;
        pend_valid_next  = 1'b0;
        pend_type_next   = 8'h00;
        pend_prio_next   = 3'h7;
        for (k_sts = 0; k_sts < NSRC; k_sts = k_sts + 1)
        begin
            // serial at bit 10, others alongside
            req_status_next[status_pos(k_sts[2:0])]  = src_req[k_sts];
            // mirror built from the same bits
            mask_mirror_next[status_pos(k_sts[2:0])] = ctl_reg[k_sts][`ISC_BLOCK_BIT];
            // lower code wins, ties to lower index
            if (src_live[k_sts] && (!pend_valid_next || ctl_reg[k_sts][2:0] < pend_prio_next))
            begin
                pend_valid_next = 1'b1;
                pend_prio_next  = ctl_reg[k_sts][2:0];
                pend_type_next  = src_type(k_sts[2:0]);
            end
        end
    end

    // =============================================================
    // Read path
    always @*
    begin
        // Unmapped offsets read zero
        rdata_next = 16'h0000;
        if (i_rd)
        begin
            if (sel_hit && sel_idx == SRC_SERIAL)
                rdata_next = {9'h000, ctl_reg[SRC_SERIAL]} | `ISC_SERIAL_FIXED;
            else if (sel_hit)
                rdata_next = {9'h000, ctl_reg[sel_idx]};
            else if (i_addr == `ISC_OFF_MASK_MIRROR)
                rdata_next = mask_mirror_next;
            else if (i_addr == `ISC_OFF_REQ_STATUS)
                rdata_next = req_status_next;
        end
    end

    // =============================================================
    // Output registers
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_reg       <= 16'h0000;
            req_status_reg  <= 16'h0000;
            mask_mirror_reg <= 16'h0000;
            pend_valid_reg  <= 1'b0;
            pend_type_reg   <= 8'h00;
            pend_prio_reg   <= 3'h7;
            ack_out_reg     <= 2'h0;
        end
        else
        begin
            rdata_reg       <= rdata_next;
            req_status_reg  <= req_status_next;
            mask_mirror_reg <= mask_mirror_next;
            pend_valid_reg  <= pend_valid_next;
            pend_type_reg   <= pend_type_next;
            pend_prio_reg   <= pend_prio_next;
            // cascade acknowledge follows service of line 0/1
            ack_out_reg     <= cascade_on & i_service_ack[1:0];
        end
    end

    assign o_rdata                 = rdata_reg;
    assign o_request_status        = req_status_reg;
    assign o_mask_mirror           = mask_mirror_reg;
    assign o_pend_valid            = pend_valid_reg;
    assign o_pend_type             = pend_type_reg;
    assign o_pend_prio             = pend_prio_reg;
    assign o_special_nested_enable = nested_on;
    assign o_cascade_enable        = cascade_on;
    assign o_ack_output_first_n    = ~ack_out_reg[0];
    assign o_ack_output_first_oe   = cascade_on[0];
    assign o_ack_output_second_n   = ~ack_out_reg[1];
    assign o_ack_output_second_oe  = cascade_on[1];

endmodule // interrupt_source_control

// ==== rtl/interrupt_source_control_map.vh ====
// Register offsets, field positions, reset values and type codes of the source control block
`ifndef INTERRUPT_SOURCE_CONTROL_MAP_VH
`define INTERRUPT_SOURCE_CONTROL_MAP_VH

// =============================================================
// Register offsets
`define ISC_OFF_LINE0_CTL   8'h38
`define ISC_OFF_LINE1_CTL   8'h3a
`define ISC_OFF_LINE2_CTL   8'h3c
`define ISC_OFF_LINE3_CTL   8'h3e
`define ISC_OFF_LINE4_CTL   8'h40
`define ISC_OFF_SOURCE_CTL  8'h44
`define ISC_OFF_MASK_MIRROR 8'h28
`define ISC_OFF_REQ_STATUS  8'h2e

// =============================================================
// Control field positions
`define ISC_PRIO_MSB        2
`define ISC_PRIO_LSB        0
`define ISC_BLOCK_BIT       3
`define ISC_LEVEL_BIT       4
`define ISC_CASCADE_BIT     5
`define ISC_NESTED_BIT      6

// Writable bits per register class
`define ISC_WMASK_LINE01    7'h7f
`define ISC_WMASK_LINE234   7'h1f
`define ISC_WMASK_INTERNAL  7'h0f

// =============================================================
// Reset values
`define ISC_RST_LINE        7'h0f
`define ISC_RST_WATCHDOG    7'h0f
`define ISC_RST_SERIAL      16'h001f
`define ISC_SERIAL_FIXED    16'h0010

// =============================================================
// Request status and mask mirror bit positions
`define ISC_POS_LINE0       4
`define ISC_POS_WATCHDOG    9
`define ISC_POS_SERIAL      10

// =============================================================
// Interrupt type codes
`define ISC_TYPE_LINE0      8'h0c
`define ISC_TYPE_LINE1      8'h0d
`define ISC_TYPE_LINE2      8'h0e
`define ISC_TYPE_LINE3      8'h0f
`define ISC_TYPE_LINE4      8'h10
`define ISC_TYPE_SERIAL     8'h14
`define ISC_TYPE_WATCHDOG   8'h11

`endif
